// >>> rtl/lcr_pkg.sv
`default_nettype none
package lcr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFS_GLOBAL_OPTIONS  = 8'h01;
  localparam logic [7:0] OFS_MODULE_GROUP    = 8'h02;
  localparam logic [7:0] OFS_GROUP_INTENSITY = 8'h03;
  localparam logic [7:0] OFS_GROUP_MIX_A     = 8'h04;
  localparam logic [7:0] OFS_GROUP_MIX_B     = 8'h05;
  localparam logic [7:0] OFS_GROUP_MIX_C     = 8'h06;
  localparam logic [7:0] OFS_MODULE0_INT     = 8'h07;
  localparam logic [7:0] OFS_MODULE2_INT     = 8'h09;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_LOG_CURVE   = 5;
  localparam int BIT_LOW_POWER   = 4;
  localparam int BIT_ADDR_STEP   = 3;
  localparam int BIT_DITHER      = 2;
  localparam int BIT_RANGE_HIGH  = 1;
  localparam int BIT_ALL_OFF     = 0;
  localparam int NUM_MODULES     = 4;
  localparam int NUM_INT_REGS    = 3;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_GLOBAL_OPTIONS  = 8'h3C;
  localparam logic [7:0] RST_MODULE_GROUP    = 8'h00;
  localparam logic [7:0] RST_GROUP_INTENSITY = 8'hFF;
  localparam logic [7:0] RST_GROUP_MIX       = 8'h00;
  localparam logic [7:0] RST_MODULE_INT      = 8'hFF;
  localparam logic [7:0] MASK_GLOBAL_OPTIONS = 8'h3F;
  localparam logic [7:0] MASK_MODULE_GROUP   = 8'h0F;
  // full-scale sink current in tenths of a milliampere
  localparam logic [9:0] CURRENT_HIGH_DMA    = 10'h15E;
  localparam logic [9:0] CURRENT_LOW_DMA     = 10'h0FF;
endpackage : lcr_pkg
`default_nettype wire

// >>> rtl/lcr_int_mem.sv
`default_nettype none
module lcr_int_mem #(
  parameter int DEPTH = 3
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 wr_en,
  input  wire logic [1:0]           wr_index,
  input  wire logic [7:0]           wr_data,
  input  wire logic [1:0]           rd_index,
  output logic      [7:0]           rd_data,
  output logic      [DEPTH*8-1:0]   all_values
);
  import lcr_pkg::*;
  logic [7:0] store [DEPTH];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        store[i] <= RST_MODULE_INT;
      end
    end else if (wr_en && (int'(wr_index) < DEPTH)) begin
      store[wr_index] <= wr_data;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= RST_MODULE_INT;
    end else if (int'(rd_index) < DEPTH) begin
      rd_data <= store[rd_index];
    end else begin
      rd_data <= 8'h00;
    end
  end
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      all_values[i*8 +: 8] = store[i];
    end
  end
endmodule : lcr_int_mem
`default_nettype wire

// >>> rtl/lcr_regs.sv
`default_nettype none
// Overview of operation
// RULE_01: bit 5 selects logarithmic, else linear dimming
// RULE_02: bit 3 lets pointer step after bytes
// RULE_03: bit 2 enables pwm dithering
// RULE_04: bit 1 picks 35 or 25.5 mA
// RULE_05: bit 0 forces every output off
// RULE_06: bits 0-3 put modules under group
// RULE_07: group intensity scales brightness, resets FFh
// RULE_08: three group mixes scale percentage, reset 00h
// RULE_09: module intensities scale brightness, reset FFh
// RULE_10: grouped modules use group intensity and mixes
// RULE_11: low-power bit stored, read back, resets one
module lcr_regs (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  input  wire logic                  addr_load,
  input  wire logic [lcr_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [lcr_pkg::DATA_W-1:0] wr_data,
  input  wire logic [7:0]            module_mix_in [4][3],
  output logic      [lcr_pkg::DATA_W-1:0] rd_data,
  output logic      [lcr_pkg::ADDR_W-1:0] reg_pointer,
  output logic                       log_curve,
  output logic                       low_power_idle,
  output logic                       dither_enable,
  output logic      [9:0]            full_scale_dma,
  output logic                       all_outputs_off,
  output logic      [3:0]            group_enables,
  output logic      [7:0]            eff_intensity [4],
  output logic      [7:0]            eff_mix [4][3]
);
  import lcr_pkg::*;
  // ************************************************************
  // register state
  // ************************************************************
  logic [7:0] global_options;
  logic [7:0] module_group_select;
  logic [7:0] group_intensity;
  logic [7:0] group_mix [3];
  logic [7:0] mem_rd_data;
  logic [23:0] module_values;
  logic [7:0] module3_intensity;
  logic [31:0] module_all;
  logic [7:0] access_addr;
  logic       mem_wr;
  logic [1:0] mem_index;
  logic [7:0] next_rd_data;
  logic       rd_from_mem;

  function automatic logic in_int_range(input logic [7:0] a);
    in_int_range = (a >= OFS_MODULE0_INT) && (a <= OFS_MODULE2_INT);
  endfunction : in_int_range

  function automatic logic [1:0] int_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFS_MODULE0_INT;
    int_index = d[1:0];
  endfunction : int_index

  // new address wins over the stored pointer in the same cycle
  assign access_addr = addr_load ? addr_in : reg_pointer;
  assign mem_wr      = wr_en && in_int_range(access_addr);
  assign mem_index   = int_index(access_addr);

  lcr_int_mem #(
    .DEPTH      (NUM_INT_REGS)
  ) u_int_mem (
    .clk        (clk),
    .reset      (reset),
    .wr_en      (mem_wr),
    .wr_index   (mem_index),
    .wr_data    (wr_data),
    .rd_index   (mem_index),
    .rd_data    (mem_rd_data),
    .all_values (module_values)
  );

  // ************************************************************
  // pointer
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_pointer <= 8'h00;
    end else if ((wr_en || rd_en) && global_options[BIT_ADDR_STEP]) begin
      reg_pointer <= access_addr + 8'h01; // RULE_02
    end else if (addr_load) begin
      reg_pointer <= addr_in; // RULE_02
    end
  end

  // ************************************************************
  // writes
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      global_options <= RST_GLOBAL_OPTIONS; // RULE_11
    end else if (wr_en && access_addr == OFS_GLOBAL_OPTIONS) begin
      global_options <= wr_data & MASK_GLOBAL_OPTIONS;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      module_group_select <= RST_MODULE_GROUP;
    end else if (wr_en && access_addr == OFS_MODULE_GROUP) begin
      module_group_select <= wr_data & MASK_MODULE_GROUP; // RULE_06
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      group_intensity <= RST_GROUP_INTENSITY; // RULE_07
    end else if (wr_en && access_addr == OFS_GROUP_INTENSITY) begin
      group_intensity <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) begin
        group_mix[i] <= RST_GROUP_MIX; // RULE_08
      end
    end else if (wr_en) begin
      if (access_addr == OFS_GROUP_MIX_A) begin
        group_mix[0] <= wr_data;
      end
      if (access_addr == OFS_GROUP_MIX_B) begin
        group_mix[1] <= wr_data;
      end
      if (access_addr == OFS_GROUP_MIX_C) begin
        group_mix[2] <= wr_data;
      end
    end
  end

  // module 3 intensity lives outside this bank; held at full scale
  assign module3_intensity = RST_MODULE_INT;
  // one flat word so the per-module select never leaves its range
  assign module_all        = {module3_intensity, module_values};

  // ************************************************************
  // read path
  // ************************************************************
  always_comb begin
    next_rd_data = 8'h00;
    case (access_addr)
      OFS_GLOBAL_OPTIONS:  next_rd_data = global_options;
      OFS_MODULE_GROUP:    next_rd_data = module_group_select;
      OFS_GROUP_INTENSITY: next_rd_data = group_intensity;
      OFS_GROUP_MIX_A:     next_rd_data = group_mix[0];
      OFS_GROUP_MIX_B:     next_rd_data = group_mix[1];
      OFS_GROUP_MIX_C:     next_rd_data = group_mix[2];
      default:             next_rd_data = 8'h00;
    endcase
  end

  // memory answers one cycle later, so the mux is picked then
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_from_mem <= 1'b0;
    end else begin
      rd_from_mem <= rd_en && in_int_range(access_addr);
    end
  end

  logic [7:0] reg_rd_data;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rd_data <= 8'h00;
    end else if (rd_en) begin
      reg_rd_data <= next_rd_data;
    end
  end
  assign rd_data = rd_from_mem ? mem_rd_data : reg_rd_data;

  // ************************************************************
  // option outputs
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      log_curve       <= RST_GLOBAL_OPTIONS[BIT_LOG_CURVE];
      low_power_idle  <= RST_GLOBAL_OPTIONS[BIT_LOW_POWER];
      dither_enable   <= RST_GLOBAL_OPTIONS[BIT_DITHER];
      full_scale_dma  <= CURRENT_LOW_DMA;
      all_outputs_off <= RST_GLOBAL_OPTIONS[BIT_ALL_OFF];
      group_enables   <= 4'h0;
    end else begin
      log_curve       <= global_options[BIT_LOG_CURVE]; // RULE_01
      low_power_idle  <= global_options[BIT_LOW_POWER]; // RULE_11
      dither_enable   <= global_options[BIT_DITHER]; // RULE_03
      full_scale_dma  <= global_options[BIT_RANGE_HIGH] ?
                         CURRENT_HIGH_DMA : CURRENT_LOW_DMA; // RULE_04
      all_outputs_off <= global_options[BIT_ALL_OFF]; // RULE_05
      group_enables   <= module_group_select[3:0]; // RULE_06
    end
  end

  // ************************************************************
  // effective values per module
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int m = 0; m < NUM_MODULES; m++) begin
        eff_intensity[m] <= RST_MODULE_INT;
        for (int c = 0; c < 3; c++) begin
          eff_mix[m][c] <= 8'h00;
        end
      end
    end else begin
      for (int m = 0; m < NUM_MODULES; m++) begin
        if (global_options[BIT_ALL_OFF]) begin
          eff_intensity[m] <= 8'h00; // RULE_05
        end else if (module_group_select[m]) begin
          eff_intensity[m] <= group_intensity; // RULE_10 RULE_07
        end else begin
          eff_intensity[m] <= module_all[m*8 +: 8]; // RULE_09
        end
        for (int c = 0; c < 3; c++) begin
          eff_mix[m][c] <= module_group_select[m] ?
                           group_mix[c] : module_mix_in[m][c]; // RULE_10
        end
      end
    end
  end
endmodule : lcr_regs
`default_nettype wire

// >>> bench/lcr_regs_properties.sv
`default_nettype none
// ************************************************************
// register bank checks
// ************************************************************
module lcr_regs_properties
  import lcr_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic       addr_load,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] reg_pointer,
  input wire logic       log_curve,
  input wire logic       low_power_idle,
  input wire logic       dither_enable,
  input wire logic [9:0] full_scale_dma,
  input wire logic       all_outputs_off,
  input wire logic [3:0] group_enables,
  input wire logic [7:0] eff_intensity [4]
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic       step;
  wire  [7:0] acc  = addr_load ? addr_in : reg_pointer;
  wire        g_wr = wr_en && addr_load && addr_in == OFS_GLOBAL_OPTIONS;
  // shadow of the step bit, the bank does not show it at a port
  always_ff @(posedge clk or posedge reset) begin
    if (reset) step <= 1'b1;
    else if (wr_en && acc == OFS_GLOBAL_OPTIONS) step <= wr_data[3];
  end
  log_curve_a: assert property (
    g_wr |-> ##2 log_curve == $past(wr_data[5], 2))
    else $error("log curve level wrong");
  // writes to the option byte itself excluded: old or new step is open
  ptr_step_a: assert property (
    (wr_en || rd_en) && acc != OFS_GLOBAL_OPTIONS |=>
    reg_pointer == $past(acc) + {7'h00, $past(step)})
    else $error("pointer step wrong");
  dither_a: assert property (
    g_wr |-> ##2 dither_enable == $past(wr_data[2], 2))
    else $error("dither level wrong");
  current_sel_a: assert property (
    g_wr |-> ##2 full_scale_dma ==
    ($past(wr_data[1], 2) ? CURRENT_HIGH_DMA : CURRENT_LOW_DMA))
    else $error("full scale current wrong");
  all_off_a: assert property (
    g_wr && wr_data[0] |-> ##2 all_outputs_off && eff_intensity[1] == 8'h00)
    else $error("outputs not forced off");
  group_bits_a: assert property (
    wr_en && addr_load && addr_in == OFS_MODULE_GROUP |-> ##2
    group_enables == $past(wr_data[3:0], 2))
    else $error("group enables wrong");
  grp_int_a: assert property (
    wr_en && addr_load && addr_in == OFS_GROUP_INTENSITY |-> ##2
    (!group_enables[0] || all_outputs_off ||
     eff_intensity[0] == $past(wr_data, 2)))
    else $error("grouped intensity wrong");
  low_power_a: assert property (
    g_wr |-> ##2 low_power_idle == $past(wr_data[4], 2))
    else $error("low power level wrong");
  cover property (g_wr && !wr_data[3]);
  cover property (rd_en && !addr_load);
  cover property (all_outputs_off && group_enables != 4'h0);
endmodule : lcr_regs_properties
`default_nettype wire

// >>> bench/lcr_host.sv
`default_nettype none
// ************************************************************
// host controller model
// ************************************************************
module lcr_host (
  input  wire logic       clk,
  output logic            wr_en,
  output logic            rd_en,
  output logic            addr_load,
  output logic      [7:0] addr_in,
  output logic      [7:0] wr_data,
  input  wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q;
  initial begin
    {wr_en, rd_en, addr_load, addr_in, wr_data} = '0;
  end
  // caller sits just after an edge; request held over one edge
  task automatic xfer(input logic w, input logic ld,
                      input logic [7:0] a, input logic [7:0] d);
    wr_en     = w;
    rd_en     = !w;
    addr_load = ld;
    addr_in   = a;
    wr_data   = d;
    @(posedge clk);
    #1;
    q = rd_data;
  endtask : xfer
  // released lines flip so a stale value cannot pass
  task automatic idle();
    {wr_en, rd_en, addr_load} = '0;
    addr_in = ~addr_in;
    wr_data = ~wr_data;
    @(posedge clk);
    #1;
  endtask : idle
endmodule : lcr_host
`default_nettype wire

// >>> bench/test_lcr_regs.sv
`default_nettype none
module test_lcr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import lcr_pkg::*;
  logic        clk, reset, wr_en, rd_en, addr_load, log_curve;
  logic        low_power_idle, dither_enable, all_outputs_off;
  logic [7:0]  addr_in, wr_data, rd_data, reg_pointer, a, d;
  logic [9:0]  full_scale_dma;
  logic [3:0]  group_enables;
  logic [7:0]  mix_in [4][3];
  logic [7:0]  eff_intensity [4];
  logic [7:0]  eff_mix [4][3];
  logic [7:0]  exp_reg [11];
  logic [31:0] seed = 32'h7936;
  int          error_cnt, tests_run, cyc;
  lcr_regs uut (.clk(clk), .reset(reset), .wr_en(wr_en), .rd_en(rd_en),
    .addr_load(addr_load), .addr_in(addr_in), .wr_data(wr_data),
    .module_mix_in(mix_in), .rd_data(rd_data), .reg_pointer(reg_pointer),
    .log_curve(log_curve), .low_power_idle(low_power_idle),
    .dither_enable(dither_enable), .full_scale_dma(full_scale_dma),
    .all_outputs_off(all_outputs_off), .group_enables(group_enables),
    .eff_intensity(eff_intensity), .eff_mix(eff_mix));
  lcr_host host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en),
    .addr_load(addr_load), .addr_in(addr_in), .wr_data(wr_data),
    .rd_data(rd_data));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  // reserved bits read zero, unmapped places read zero
  function automatic logic [7:0] msk(logic [7:0] ad, logic [7:0] dt);
    if (ad == 8'h01) return dt & 8'h3F;
    if (ad == 8'h02) return dt & 8'h0F;
    return (ad == 8'h00 || ad > 8'h09) ? 8'h00 : dt;
  endfunction : msk
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    host.xfer(1'b1, 1'b1, ad, dt);
    exp_reg[ad] = msk(ad, dt);
  endtask : wr
  task automatic rd(input logic ld, input logic [7:0] ad);
    host.xfer(1'b0, ld, ad, 8'h00);
    chk(host.q, exp_reg[ad]);
  endtask : rd
  task automatic chk_out();
    logic [7:0] g, e;
    g = exp_reg[1];
    chk(log_curve, g[5]);
    chk(dither_enable, g[2]);
    chk(low_power_idle, g[4]);
    chk(full_scale_dma, g[1] ? 10'h15E : 10'h0FF);
    chk(all_outputs_off, g[0]);
    chk(group_enables, exp_reg[2][3:0]);
    for (int i = 0; i < 4; i++) begin
      e = exp_reg[2][i] ? exp_reg[3] : (i < 3 ? exp_reg[7+i] : 8'hFF);
      chk(eff_intensity[i], g[0] ? 8'h00 : e);
      for (int j = 0; j < 3; j++) begin
        e = exp_reg[2][i] ? exp_reg[4+j] : mix_in[i][j];
        chk(eff_mix[i][j], e);
      end
    end
  endtask : chk_out
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    reset = 1'b1;
    exp_reg = '{8'h00, 8'h3C, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
                8'hFF, 8'hFF, 8'hFF, 8'h00};
    foreach (mix_in[i, j]) mix_in[i][j] = 8'h00;
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    // reset values, walked with the stepping pointer
    rd(1'b1, 8'h01);
    for (int k = 2; k < 10; k++) begin
      rd(1'b0, k[7:0]);
    end
    host.idle();
    chk_out();
    $display("test reset values done");
    for (int n = 0; n < 60; n++) begin
      a = rnd() % 8'd11;
      d = rnd();
      foreach (mix_in[i, j]) mix_in[i][j] = rnd();
      wr(a, d);
      rd(1'b1, a);
      host.idle();
      host.idle();
      chk_out();
    end
    $display("test random access done");
    // step off: an unloaded second byte lands on the same register
    wr(8'h01, 8'h34);
    wr(8'h03, 8'h80);
    host.xfer(1'b1, 1'b0, 8'h00, 8'h00);
    exp_reg[3] = 8'h00;
    chk(reg_pointer, 8'h03);
    wr(8'h02, 8'hFF);
    wr(8'h01, 8'hFF);
    rd(1'b1, 8'h03);
    host.idle();
    host.idle();
    chk_out();
    $display("test corner cases done");
    summarize();
  end
endmodule : test_lcr_regs
bind lcr_regs lcr_regs_properties chk_i (.clk(clk), .reset(reset),
  .wr_en(wr_en), .rd_en(rd_en), .addr_load(addr_load),
  .addr_in(addr_in), .wr_data(wr_data), .reg_pointer(reg_pointer),
  .log_curve(log_curve), .low_power_idle(low_power_idle),
  .dither_enable(dither_enable), .full_scale_dma(full_scale_dma),
  .all_outputs_off(all_outputs_off), .group_enables(group_enables),
  .eff_intensity(eff_intensity));
`default_nettype wire
